/* File: rtl/bsc_pkg.sv */
// Purpose: shared constants and types for the branch and stack control unit
// Assumes: one clock domain, synchronous active-low reset
// Notes:   cycle counts are whole instruction cycles
package bsc_pkg;

   localparam int unsigned BSC_CYC_ACC_TAKEN   = 5;
   localparam int unsigned BSC_CYC_ACC_FALL    = 4;
   localparam int unsigned BSC_CYC_RB_TAKEN    = 13;
   localparam int unsigned BSC_CYC_RB_FALL     = 12;
   localparam int unsigned BSC_CYC_RW_TAKEN    = 8;
   localparam int unsigned BSC_CYC_RW_FALL     = 7;
   localparam int unsigned BSC_CYC_MCMP_TAKEN  = 7;
   localparam int unsigned BSC_CYC_MCMP_FALL   = 6;
   localparam int unsigned BSC_CYC_RDEC_TAKEN  = 7;
   localparam int unsigned BSC_CYC_RDEC_FALL   = 6;
   localparam int unsigned BSC_CYC_MDEC_TAKEN  = 8;
   localparam int unsigned BSC_CYC_MDEC_FALL   = 7;
   localparam int unsigned BSC_CYC_BR_TAKEN    = 4;
   localparam int unsigned BSC_CYC_BR_FALL     = 3;
   localparam int unsigned BSC_CYC_RET         = 4;
   localparam int unsigned BSC_CYC_RETF        = 6;
   localparam int unsigned BSC_CYC_LINK        = 6;
   localparam int unsigned BSC_CYC_CALL        = 6;
   localparam int unsigned BSC_CYC_CALLF       = 10;
   localparam int unsigned BSC_CYC_JIND        = 4;
   localparam int unsigned BSC_LEN_CMP_BYTE    = 3;
   localparam int unsigned BSC_LEN_CMP_WORD    = 4;

   localparam logic [15:0] BSC_RST_PC          = 16'h0000;
   localparam logic [7:0]  BSC_RST_BANK        = 8'h00;
   localparam logic [15:0] BSC_RST_SP          = 16'h0000;
   localparam logic [15:0] BSC_RST_FP          = 16'h0000;

   localparam int unsigned BSC_FLG_C           = 0;
   localparam int unsigned BSC_FLG_V           = 1;
   localparam int unsigned BSC_FLG_Z           = 2;
   localparam int unsigned BSC_FLG_N           = 3;
   localparam int unsigned BSC_FLG_T           = 4;

   typedef enum logic [3:0] {
      BSC_OP_NONE,
      BSC_OP_CMP_ACC,
      BSC_OP_CMP_REG,
      BSC_OP_CMP_MEM,
      BSC_OP_DEC_REG,
      BSC_OP_DEC_MEM,
      BSC_OP_BRANCH,
      BSC_OP_RET,
      BSC_OP_RETF,
      BSC_OP_LINK,
      BSC_OP_CALL,
      BSC_OP_CALLF,
      BSC_OP_JIND
   } bsc_op_t;

   typedef enum logic [3:0] {
      BSC_CC_ZS, BSC_CC_ZC, BSC_CC_CS, BSC_CC_CC,
      BSC_CC_NS, BSC_CC_NC, BSC_CC_VS, BSC_CC_VC,
      BSC_CC_TS, BSC_CC_TC, BSC_CC_LT, BSC_CC_GE,
      BSC_CC_LE, BSC_CC_GT, BSC_CC_LS, BSC_CC_HI
   } bsc_cc_t;

   typedef struct packed {
      bsc_op_t     op;
      logic        word;
      logic        always_br;
      bsc_cc_t     cond;
      logic [15:0] operand;
      logic [15:0] imm;
      logic [15:0] target;
      logic [7:0]  target_bank;
      logic [7:0]  rel;
      logic [7:0]  local_size;
      logic [15:0] mem_addr;
      logic [7:0]  mode_extra;
   } bsc_instr_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        lock;
      logic        word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bsc_mem_req_t;

endpackage : bsc_pkg

/* File: rtl/bsc_cmp_alu.sv */
// Purpose: subtract and decrement unit giving result and condition flags
// Assumes: purely combinational
// Notes:   byte mode works on the low eight bits only
`timescale 1ns/100ps
module bsc_cmp_alu
   import bsc_pkg::*;
(
   input  wire logic        i_word,
   input  wire logic        i_dec,
   input  wire logic [15:0] i_a,
   input  wire logic [15:0] i_b,
   output logic      [15:0] o_res,
   output logic             o_n,
   output logic             o_z,
   output logic             o_v,
   output logic             o_c
);
   logic [16:0] diff;
   logic [15:0] subtr;

   always_comb begin
      subtr = i_dec ? 16'h0001 : i_b;
      diff  = {1'b0, i_a} - {1'b0, subtr};
      if (i_word) begin
         o_res = diff[15:0];
         o_n   = diff[15];
         o_z   = (diff[15:0] == 16'h0000);
         o_v   = (i_a[15] ^ subtr[15]) & (i_a[15] ^ diff[15]);
         o_c   = diff[16];
      end else begin
         o_res = {8'h00, i_a[7:0] - subtr[7:0]};
         o_n   = o_res[7];
         o_z   = (o_res[7:0] == 8'h00);
         o_v   = (i_a[7] ^ subtr[7]) & (i_a[7] ^ o_res[7]);
         o_c   = (i_a[7:0] < subtr[7:0]);
      end
   end
endmodule // bsc_cmp_alu

/* File: rtl/bsc_exec.sv */
// Purpose: executes compare/decrement branches, returns, frame link, calls, jumps
// Assumes: decoder delivers one instruction at a time, memory answers in one cycle
// Notes:   busy holds for one cycle less than the documented cycle count; done fills the last cycle
// Summary of operation
// - byte compare accumulator low byte to imm8, branch if unequal, set NZVC
// - word compare accumulator to imm16, branch if unequal, set NZVC
// - accumulator compare forms: five cycles taken, four fall-through
// - byte compare on register: thirteen cycles taken, twelve not
// - memory compare forms: seven plus mode overhead taken, six plus not
// - word compare on register: eight cycles taken, seven not
// - register decrement-branch writes back, branches nonzero, NZV set, 7/6
// - memory decrement-branch uses locked read-modify-write, eight/seven plus overhead
// - short relative branches take four cycles taken, three not
// - near return pops one word into program counter, four cycles
// - far return pops long word into counter and bank, six cycles
// - link pushes frame pointer, copies stack pointer, reserves local area, six
// - near call pushes one-word return address before jumping
// - far call pushes counter and bank as long word, ten cycles
// - indirect jump reads one-word target from operand address
`timescale 1ns/100ps
module bsc_exec
   import bsc_pkg::*;
(
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst_n,
   input  wire logic         i_start,
   input  wire bsc_instr_t   i_instr,
   input  wire logic [15:0]  i_next_pc,
   input  wire logic [7:0]   i_flags,
   input  wire logic [15:0]  i_mem_rdata,
   output logic              o_busy,
   output logic              o_done,
   output logic              o_taken,
   output logic [15:0]       o_pc,
   output logic [7:0]        o_bank,
   output logic [15:0]       o_sp,
   output logic [15:0]       o_fp,
   output logic [7:0]        o_flags,
   output logic              o_flags_we,
   output logic [15:0]       o_reg_wdata,
   output logic              o_reg_we,
   output bsc_mem_req_t      o_mem
);
   typedef enum logic [2:0] {BSC_ST_IDLE, BSC_ST_MEM1, BSC_ST_MEM2, BSC_ST_WAIT} bsc_st_t;

   bsc_st_t      st_q;
   bsc_instr_t   ins_q;
   logic [7:0]   cnt_q;
   logic         taken_q;
   logic         done_q;
   logic         busy_q;
   logic [15:0]  pc_q;
   logic [7:0]   bank_q;
   logic [15:0]  sp_q;
   logic [15:0]  fp_q;
   logic [7:0]   flags_q;
   logic         flags_we_q;
   logic [15:0]  reg_wdata_q;
   logic         reg_we_q;
   bsc_mem_req_t mem_q;
   logic [15:0]  ret_pc_q;
   logic [15:0]  opnd;
   logic [15:0]  alu_res;
   logic         alu_n;
   logic         alu_z;
   logic         alu_v;
   logic         alu_c;
   logic         alu_dec;
   logic         alu_word;

   function automatic logic cond_true(input bsc_cc_t cc, input logic [7:0] f);
      logic n;
      logic z;
      logic v;
      logic c;
      n = f[BSC_FLG_N];
      z = f[BSC_FLG_Z];
      v = f[BSC_FLG_V];
      c = f[BSC_FLG_C];
      case (cc)
         BSC_CC_ZS: cond_true = z;
         BSC_CC_ZC: cond_true = !z;
         BSC_CC_CS: cond_true = c;
         BSC_CC_CC: cond_true = !c;
         BSC_CC_NS: cond_true = n;
         BSC_CC_NC: cond_true = !n;
         BSC_CC_VS: cond_true = v;
         BSC_CC_VC: cond_true = !v;
         BSC_CC_TS: cond_true = f[BSC_FLG_T];
         BSC_CC_TC: cond_true = !f[BSC_FLG_T];
         BSC_CC_LT: cond_true = v ^ n;
         BSC_CC_GE: cond_true = !(v ^ n);
         BSC_CC_LE: cond_true = (v ^ n) | z;
         BSC_CC_GT: cond_true = !((v ^ n) | z);
         BSC_CC_LS: cond_true = c | z;
         BSC_CC_HI: cond_true = !(c | z);
         default:   cond_true = 1'b0;
      endcase
   endfunction

   function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] rel);
      rel_target = pc + {{8{rel[7]}}, rel};
   endfunction

   function automatic logic [7:0] cycles(input logic [7:0] t, input logic [7:0] f, input logic br);
      cycles = br ? t : f;
   endfunction

   // memory operands come from the bus, others from the decoder
   assign opnd     = (ins_q.op == BSC_OP_CMP_MEM || ins_q.op == BSC_OP_DEC_MEM) ? i_mem_rdata : ins_q.operand;
   assign alu_dec  = (ins_q.op == BSC_OP_DEC_REG || ins_q.op == BSC_OP_DEC_MEM);
   assign alu_word = ins_q.word;

   bsc_cmp_alu u_alu (
      .i_word (alu_word),
      .i_dec  (alu_dec),
      .i_a    (opnd),
      .i_b    (ins_q.imm),
      .o_res  (alu_res),
      .o_n    (alu_n),
      .o_z    (alu_z),
      .o_v    (alu_v),
      .o_c    (alu_c)
   );

   // sequencer and cycle counting
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st_q    <= BSC_ST_IDLE;
         ins_q   <= '0;
         cnt_q   <= 8'h00;
         taken_q <= 1'b0;
         done_q  <= 1'b0;
         busy_q  <= 1'b0;
         ret_pc_q <= BSC_RST_PC;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            BSC_ST_IDLE: begin
               if (i_start && i_instr.op != BSC_OP_NONE) begin
                  ins_q    <= i_instr;
                  ret_pc_q <= i_next_pc;
                  taken_q  <= 1'b0;
                  busy_q   <= 1'b1;
                  st_q     <= BSC_ST_MEM1;
               end
            end
            BSC_ST_MEM1: begin
               st_q <= BSC_ST_WAIT;
               case (ins_q.op)
                  BSC_OP_CMP_ACC: begin
                     taken_q <= !alu_z;
                     cnt_q   <= cycles(8'(BSC_CYC_ACC_TAKEN), 8'(BSC_CYC_ACC_FALL), !alu_z) - 8'h02;
                  end
                  BSC_OP_CMP_REG: begin
                     taken_q <= !alu_z;
                     cnt_q   <= ins_q.word
                        ? cycles(8'(BSC_CYC_RW_TAKEN), 8'(BSC_CYC_RW_FALL), !alu_z) - 8'h02
                        : cycles(8'(BSC_CYC_RB_TAKEN), 8'(BSC_CYC_RB_FALL), !alu_z) - 8'h02;
                  end
                  BSC_OP_CMP_MEM: begin
                     taken_q <= !alu_z;
                     cnt_q   <= cycles(8'(BSC_CYC_MCMP_TAKEN), 8'(BSC_CYC_MCMP_FALL), !alu_z)
                                + ins_q.mode_extra - 8'h02;
                  end
                  BSC_OP_DEC_REG: begin
                     taken_q <= !alu_z;
                     cnt_q   <= cycles(8'(BSC_CYC_RDEC_TAKEN), 8'(BSC_CYC_RDEC_FALL), !alu_z) - 8'h02;
                  end
                  BSC_OP_DEC_MEM: begin
                     taken_q <= !alu_z;
                     st_q    <= BSC_ST_MEM2;
                     cnt_q   <= cycles(8'(BSC_CYC_MDEC_TAKEN), 8'(BSC_CYC_MDEC_FALL), !alu_z)
                                + ins_q.mode_extra - 8'h03;
                  end
                  BSC_OP_BRANCH: begin
                     taken_q <= ins_q.always_br | cond_true(ins_q.cond, i_flags);
                     cnt_q   <= cycles(8'(BSC_CYC_BR_TAKEN), 8'(BSC_CYC_BR_FALL),
                                       ins_q.always_br | cond_true(ins_q.cond, i_flags)) - 8'h02;
                  end
                  BSC_OP_RET:   cnt_q <= 8'(BSC_CYC_RET) - 8'h02;
                  BSC_OP_RETF:  begin
                     st_q  <= BSC_ST_MEM2;
                     cnt_q <= 8'(BSC_CYC_RETF) - 8'h03;
                  end
                  BSC_OP_LINK:  cnt_q <= 8'(BSC_CYC_LINK) - 8'h02;
                  BSC_OP_CALL:  cnt_q <= 8'(BSC_CYC_CALL) - 8'h02;
                  BSC_OP_CALLF: begin
                     st_q  <= BSC_ST_MEM2;
                     cnt_q <= 8'(BSC_CYC_CALLF) - 8'h03;
                  end
                  BSC_OP_JIND:  cnt_q <= 8'(BSC_CYC_JIND) - 8'h02;
                  default:      cnt_q <= 8'h00;
               endcase
            end
            BSC_ST_MEM2: st_q <= BSC_ST_WAIT;
            BSC_ST_WAIT: begin
               if (cnt_q <= 8'h01) begin
                  st_q   <= BSC_ST_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: st_q <= BSC_ST_IDLE;
         endcase
      end
   end

   // memory requests, one word per cycle; far return reads the low word first, far call pushes the bank word first
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         mem_q <= '0;
      end else begin
         mem_q <= '0;
         if (st_q == BSC_ST_IDLE && i_start) begin
            case (i_instr.op)
               BSC_OP_CMP_MEM, BSC_OP_JIND: begin
                  mem_q.rd   <= 1'b1;
                  mem_q.word <= i_instr.word | (i_instr.op == BSC_OP_JIND);
                  mem_q.addr <= i_instr.mem_addr;
               end
               BSC_OP_DEC_MEM: begin
                  mem_q.rd   <= 1'b1;
                  mem_q.lock <= 1'b1;
                  mem_q.word <= i_instr.word;
                  mem_q.addr <= i_instr.mem_addr;
               end
               BSC_OP_RET, BSC_OP_RETF: begin
                  mem_q.rd   <= 1'b1;
                  mem_q.word <= 1'b1;
                  mem_q.addr <= sp_q;
               end
               BSC_OP_LINK: begin
                  mem_q.wr    <= 1'b1;
                  mem_q.word  <= 1'b1;
                  mem_q.addr  <= sp_q - 16'h0002;
                  mem_q.wdata <= fp_q;
               end
               BSC_OP_CALL: begin
                  mem_q.wr    <= 1'b1;
                  mem_q.word  <= 1'b1;
                  mem_q.addr  <= sp_q - 16'h0002;
                  mem_q.wdata <= i_next_pc;
               end
               BSC_OP_CALLF: begin
                  mem_q.wr    <= 1'b1;
                  mem_q.word  <= 1'b1;
                  mem_q.addr  <= sp_q - 16'h0002;
                  mem_q.wdata <= {8'h00, bank_q};
               end
               default: mem_q <= '0;
            endcase
         end else if (st_q == BSC_ST_MEM1) begin
            case (ins_q.op)
               BSC_OP_DEC_MEM: begin
                  mem_q.wr    <= 1'b1;
                  mem_q.lock  <= 1'b1;
                  mem_q.word  <= ins_q.word;
                  mem_q.addr  <= ins_q.mem_addr;
                  mem_q.wdata <= alu_res;
               end
               BSC_OP_RETF: begin
                  mem_q.rd   <= 1'b1;
                  mem_q.word <= 1'b1;
                  mem_q.addr <= sp_q + 16'h0002;
               end
               BSC_OP_CALLF: begin
                  mem_q.wr    <= 1'b1;
                  mem_q.word  <= 1'b1;
                  mem_q.addr  <= sp_q - 16'h0004;
                  mem_q.wdata <= ret_pc_q;
               end
               default: mem_q <= '0;
            endcase
         end
      end
   end

   // program counter, bank, stack and frame pointers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pc_q   <= BSC_RST_PC;
         bank_q <= BSC_RST_BANK;
         sp_q   <= BSC_RST_SP;
         fp_q   <= BSC_RST_FP;
      end else if (st_q == BSC_ST_MEM1) begin
         case (ins_q.op)
            BSC_OP_CMP_ACC, BSC_OP_CMP_REG, BSC_OP_CMP_MEM,
            BSC_OP_DEC_REG, BSC_OP_DEC_MEM:
               pc_q <= !alu_z ? rel_target(ret_pc_q, ins_q.rel) : ret_pc_q;
            BSC_OP_BRANCH:
               pc_q <= (ins_q.always_br | cond_true(ins_q.cond, i_flags))
                       ? rel_target(ret_pc_q, ins_q.rel) : ret_pc_q;
            BSC_OP_RET: begin
               pc_q <= i_mem_rdata;
               sp_q <= sp_q + 16'h0002;
            end
            BSC_OP_RETF: pc_q <= i_mem_rdata;
            BSC_OP_LINK: begin
               fp_q <= sp_q - 16'h0002;
               sp_q <= sp_q - 16'h0002 - {8'h00, ins_q.local_size};
            end
            BSC_OP_CALL: begin
               pc_q <= ins_q.target;
               sp_q <= sp_q - 16'h0002;
            end
            BSC_OP_CALLF: begin
               pc_q   <= ins_q.target;
               bank_q <= ins_q.target_bank;
               sp_q   <= sp_q - 16'h0004;
            end
            BSC_OP_JIND: pc_q <= i_mem_rdata;
            default: pc_q <= pc_q;
         endcase
      end else if (st_q == BSC_ST_MEM2 && ins_q.op == BSC_OP_RETF) begin
         bank_q <= i_mem_rdata[7:0];
         sp_q   <= sp_q + 16'h0004;
      end
   end

   // flags and register write-back
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         flags_q     <= 8'h00;
         flags_we_q  <= 1'b0;
         reg_wdata_q <= 16'h0000;
         reg_we_q    <= 1'b0;
      end else begin
         flags_we_q <= 1'b0;
         reg_we_q   <= 1'b0;
         if (st_q == BSC_ST_MEM1) begin
            case (ins_q.op)
               BSC_OP_CMP_ACC, BSC_OP_CMP_REG, BSC_OP_CMP_MEM: begin
                  flags_q <= i_flags;
                  flags_q[BSC_FLG_N] <= alu_n;
                  flags_q[BSC_FLG_Z] <= alu_z;
                  flags_q[BSC_FLG_V] <= alu_v;
                  flags_q[BSC_FLG_C] <= alu_c;
                  flags_we_q <= 1'b1;
               end
               BSC_OP_DEC_REG, BSC_OP_DEC_MEM: begin
                  flags_q <= i_flags;
                  flags_q[BSC_FLG_N] <= alu_n;
                  flags_q[BSC_FLG_Z] <= alu_z;
                  flags_q[BSC_FLG_V] <= alu_v;
                  flags_we_q <= 1'b1;
                  reg_wdata_q <= alu_res;
                  reg_we_q    <= (ins_q.op == BSC_OP_DEC_REG);
               end
               default: flags_q <= flags_q;
            endcase
         end
      end
   end

   assign o_busy      = busy_q;
   assign o_done      = done_q;
   assign o_taken     = taken_q;
   assign o_pc        = pc_q;
   assign o_bank      = bank_q;
   assign o_sp        = sp_q;
   assign o_fp        = fp_q;
   assign o_flags     = flags_q;
   assign o_flags_we  = flags_we_q;
   assign o_reg_wdata = reg_wdata_q;
   assign o_reg_we    = reg_we_q;
   assign o_mem       = mem_q;
endmodule // bsc_exec

/* File: tb/bsc_exec_sva.sv */
// Purpose: port checks for bsc_exec
// Assumes: one clock, synchronous active-low reset
// Notes:   counts run from the start edge to the done cycle
`timescale 1ns/100ps
module bsc_exec_sva
   import bsc_pkg::*;
(
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst_n,
   input  wire logic         i_start,
   input  wire bsc_instr_t   i_instr,
   input  wire logic         o_busy,
   input  wire logic         o_done,
   input  wire logic         o_taken,
   input  wire logic [7:0]   o_flags,
   input  wire logic         o_flags_we,
   input  wire logic [15:0]  o_reg_wdata,
   input  wire logic         o_reg_we,
   input  wire bsc_mem_req_t o_mem
);
   bsc_op_t     op;
   bsc_instr_t  ins_q;
   logic [7:0]  cnt_q;
   logic [15:0] dif;
   logic        cmpx;
   assign op   = (i_start && !o_busy) ? i_instr.op : BSC_OP_NONE;
   assign dif  = ins_q.operand - ins_q.imm;
   assign cmpx = ins_q.op == BSC_OP_CMP_ACC || ins_q.op == BSC_OP_CMP_REG;
   // cycles since the start edge
   always_ff @(posedge i_clk_sys) begin
      cnt_q <= (op != BSC_OP_NONE || !i_rst_n) ? 8'h01 : cnt_q + 8'h01;
   end
   always_ff @(posedge i_clk_sys) begin
      if (op != BSC_OP_NONE) ins_q <= i_instr;
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   sequence s_busy3; o_busy[*3]; endsequence
   sequence s_lock; (o_mem.rd && o_mem.lock) ##1 (o_mem.wr && o_mem.lock); endsequence
   property p_ret; op == BSC_OP_RET |-> ##1 s_busy3 ##1 o_done; endproperty
   a_ret: assert property (p_ret) else $error("near return length wrong");
   property p_callf; op == BSC_OP_CALLF |-> ##1 o_busy[*8] ##1 o_busy ##1 o_done; endproperty
   a_callf: assert property (p_callf) else $error("far call length wrong");
   property p_acc;
      op == BSC_OP_CMP_ACC |-> (##4 (o_done && !o_taken)) or (##5 (o_done && o_taken));
   endproperty
   a_acc: assert property (p_acc) else $error("accumulator compare length wrong");
   property p_br;
      op == BSC_OP_BRANCH |-> (##3 (o_done && !o_taken)) or (##4 (o_done && o_taken));
   endproperty
   a_br: assert property (p_br) else $error("short branch length wrong");
   property p_rdec;
      op == BSC_OP_DEC_REG |-> (##6 (o_done && !o_taken)) or (##7 (o_done && o_taken));
   endproperty
   a_rdec: assert property (p_rdec) else $error("register decrement length wrong");
   property p_mcnt;
      o_done && (ins_q.op == BSC_OP_CMP_MEM || ins_q.op == BSC_OP_DEC_MEM) |->
         cnt_q == ins_q.mode_extra + (o_taken ? 8'h07 : 8'h06) + 8'(ins_q.op == BSC_OP_DEC_MEM);
   endproperty
   a_mcnt: assert property (p_mcnt) else $error("memory form length wrong");
   property p_lock; op == BSC_OP_DEC_MEM |-> ##1 s_lock; endproperty
   a_lock: assert property (p_lock) else $error("locked read-modify-write missing");
   property p_cmp;
      o_done && cmpx |->
         o_taken == (ins_q.word ? ins_q.operand != ins_q.imm : ins_q.operand[7:0] != ins_q.imm[7:0]);
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare branch decision wrong");
   property p_flg;
      o_flags_we && cmpx && ins_q.word |-> o_flags[BSC_FLG_Z] == (dif == 16'h0000)
         && o_flags[BSC_FLG_N] == dif[15] && o_flags[BSC_FLG_C] == (ins_q.operand < ins_q.imm);
   endproperty
   a_flg: assert property (p_flg) else $error("compare flags wrong");
   property p_wb;
      op == BSC_OP_DEC_REG |-> ##2 o_reg_we && o_reg_wdata[7:0] == ins_q.operand[7:0] - 8'h01
         && (!ins_q.word || o_reg_wdata == ins_q.operand - 16'h0001);
   endproperty
   a_wb: assert property (p_wb) else $error("decrement write-back wrong");
   property p_jind; op == BSC_OP_JIND |-> ##1 (o_mem.rd && o_mem.addr == ins_q.mem_addr); endproperty
   a_jind: assert property (p_jind) else $error("indirect jump read wrong");
endmodule // bsc_exec_sva
bind bsc_exec bsc_exec_sva u_sva (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start), .i_instr(i_instr), .o_busy(o_busy),
   .o_done(o_done), .o_taken(o_taken), .o_flags(o_flags), .o_flags_we(o_flags_we),
   .o_reg_wdata(o_reg_wdata), .o_reg_we(o_reg_we), .o_mem(o_mem)
);

/* File: tb/bsc_mem_model.sv */
// Purpose: operand and stack memory for bsc_exec
// Assumes: word accesses, address bits 8:1 pick one of 256 words
// Notes:   reads answer at once; idle data turns over each cycle
`timescale 1ns/100ps
module bsc_mem_model
   import bsc_pkg::*;
(
   input  wire logic         i_clk_sys,
   input  wire bsc_mem_req_t i_mem,
   output logic [15:0]       o_rdata
);
   logic [15:0] mem_q [256];
   logic [15:0] last_q = 16'h0000;
   assign o_rdata = i_mem.rd ? mem_q[i_mem.addr[8:1]] : ~last_q;
   always @(posedge i_clk_sys) begin
      if (i_mem.wr) mem_q[i_mem.addr[8:1]] <= i_mem.wdata;
      last_q <= o_rdata;
   end
endmodule // bsc_mem_model

/* File: tb/bsc_exec_tb.sv */
// Purpose: directed bench for bsc_exec
// Assumes: memory model answers in the cycle of a read request
// Notes:   cycles counted from start edge to done cycle
`timescale 1ns/100ps
module bsc_exec_tb
   import bsc_pkg::*;
;
   logic         i_clk_sys = 1'b0;
   logic         i_rst_n   = 1'b0;
   logic         i_start   = 1'b0;
   bsc_instr_t   i_instr   = '0;
   logic [15:0]  i_next_pc = 16'h0000;
   logic [7:0]   i_flags   = 8'h00;
   logic [15:0]  i_mem_rdata;
   logic         o_busy, o_done, o_taken, o_flags_we, o_reg_we;
   logic [15:0]  o_pc, o_sp, o_fp, o_reg_wdata;
   logic [7:0]   o_bank, o_flags;
   bsc_mem_req_t o_mem;
   bsc_instr_t   ins;
   int           fails = 0;
   int           cmp_count = 0;
   always #2 i_clk_sys = ~i_clk_sys;
   bsc_exec DUT (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start), .i_instr(i_instr),
      .i_next_pc(i_next_pc), .i_flags(i_flags), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy),
      .o_done(o_done), .o_taken(o_taken), .o_pc(o_pc), .o_bank(o_bank), .o_sp(o_sp), .o_fp(o_fp),
      .o_flags(o_flags), .o_flags_we(o_flags_we), .o_reg_wdata(o_reg_wdata), .o_reg_we(o_reg_we),
      .o_mem(o_mem)
   );
   bsc_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_mem(o_mem), .o_rdata(i_mem_rdata));
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task set(input bsc_op_t op, input logic w, input logic [15:0] a, input logic [15:0] b, input logic [7:0] x);
      ins = '0;
      ins.op = op;
      ins.word = w;
      ins.operand = a;
      ins.imm = b;
      ins.mode_extra = x;
   endtask
   task run(input string nm, input int n, input logic tk);
      int k;
      i_instr = ins;
      i_start = 1'b1;
      for (k = 1; k <= 40; k++) begin
         @(negedge i_clk_sys);
         if (k == 1) i_start = 1'b0;
         if (o_done === 1'b1) break;
      end
      if (k > 40) begin
         fails++;
         finish_test();
      end
      chk(nm, 16'(k), 16'(n));
      if (tk !== 1'bx) chk(nm, 16'(o_taken), 16'(tk));
   endtask
   initial begin
      int c;
      repeat (4) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      @(negedge i_clk_sys);
      set(BSC_OP_CMP_ACC, 1'b0, 16'h1234, 16'hFF34, 8'h00);
      run("acc b eq", 4, 1'b0);
      set(BSC_OP_CMP_ACC, 1'b0, 16'h0012, 16'h0013, 8'h00);
      run("acc b ne", 5, 1'b1);
      set(BSC_OP_CMP_ACC, 1'b1, 16'h1234, 16'h1235, 8'h00);
      run("acc w ne", 5, 1'b1);
      chk("flags", 16'(o_flags[3:0]), 16'h0009);
      set(BSC_OP_CMP_ACC, 1'b1, 16'h8000, 16'h0001, 8'h00);
      run("acc w ov", 5, 1'b1);
      chk("flags", 16'(o_flags[3:0]), 16'h0002);
      set(BSC_OP_CMP_ACC, 1'b1, 16'h8000, 16'h8000, 8'h00);
      run("acc w eq", 4, 1'b0);
      chk("flags", 16'(o_flags[3:0]), 16'h0004);
      set(BSC_OP_CMP_REG, 1'b0, 16'hAA55, 16'h0055, 8'h00);
      run("reg b eq", 12, 1'b0);
      ins.imm = 16'h0056;
      run("reg b ne", 13, 1'b1);
      ins.word = 1'b1;
      run("reg w ne", 8, 1'b1);
      ins.imm = 16'hAA55;
      run("reg w eq", 7, 1'b0);
      // memory compares with three cycles of mode overhead
      u_mem.mem_q[8'h08] = 16'h11C3;
      set(BSC_OP_CMP_MEM, 1'b0, 16'h0000, 16'h00C3, 8'h03);
      ins.mem_addr = 16'h0010;
      run("mem b eq", 9, 1'b0);
      ins.word = 1'b1;
      run("mem w ne", 10, 1'b1);
      i_flags = 8'h01;
      set(BSC_OP_DEC_REG, 1'b1, 16'h0001, 16'h0000, 8'h00);
      run("dec w", 6, 1'b0);
      chk("carry", 16'(o_flags[BSC_FLG_C]), 16'h0001);
      ins.word = 1'b0;
      ins.operand = 16'h0100;
      run("dec b", 7, 1'b1);
      i_flags = 8'h00;
      u_mem.mem_q[8'h09] = 16'h0002;
      set(BSC_OP_DEC_MEM, 1'b1, 16'h0000, 16'h0000, 8'h02);
      ins.mem_addr = 16'h0012;
      run("mdec 2", 10, 1'b1);
      chk("mdec wr", u_mem.mem_q[8'h09], 16'h0001);
      run("mdec 1", 9, 1'b0);
      chk("mdec wr", u_mem.mem_q[8'h09], 16'h0000);
      // with all flags clear, odd codes hold and even codes fail
      for (c = 0; c < 16; c++) begin
         set(BSC_OP_BRANCH, 1'b0, 16'h0000, 16'h0000, 8'h00);
         ins.cond = bsc_cc_t'(c);
         run("cond br", 3 + c % 2, c[0]);
      end
      ins.always_br = 1'b1;
      ins.cond = BSC_CC_ZS;
      run("always br", 4, 1'b1);
      i_next_pc = 16'hABCD;
      set(BSC_OP_CALL, 1'b0, 16'h0000, 16'h0000, 8'h00);
      ins.target = 16'h0040;
      run("call", BSC_CYC_CALL, 1'bx);
      chk("call push", u_mem.mem_q[8'hFF], 16'hABCD);
      chk("call pc", o_pc, 16'h0040);
      set(BSC_OP_RET, 1'b0, 16'h0000, 16'h0000, 8'h00);
      run("ret", 4, 1'bx);
      chk("ret pc", o_pc, 16'hABCD);
      i_next_pc = 16'h1357;
      set(BSC_OP_CALLF, 1'b0, 16'h0000, 16'h0000, 8'h00);
      ins.target = 16'h2468;
      ins.target_bank = 8'h5A;
      run("callf", 10, 1'bx);
      chk("push pc", u_mem.mem_q[8'hFE], 16'h1357);
      chk("push bank", u_mem.mem_q[8'hFF], 16'h0000);
      set(BSC_OP_RETF, 1'b0, 16'h0000, 16'h0000, 8'h00);
      run("retf", 6, 1'bx);
      chk("retf pc", o_pc, 16'h1357);
      chk("retf bank", 16'(o_bank), 16'h0000);
      set(BSC_OP_LINK, 1'b0, 16'h0000, 16'h0000, 8'h00);
      ins.local_size = 8'h04;
      run("link", 6, 1'bx);
      chk("link fp", o_fp, 16'hFFFE);
      chk("link sp", o_sp, 16'hFFFA);
      u_mem.mem_q[8'h10] = 16'h0777;
      set(BSC_OP_JIND, 1'b0, 16'h0000, 16'h0000, 8'h00);
      ins.mem_addr = 16'h0020;
      run("jind", BSC_CYC_JIND, 1'bx);
      chk("jind pc", o_pc, 16'h0777);
      finish_test();
   end
endmodule // bsc_exec_tb
